// [hw/phy_ctl_cfg.svh]
// Offsets, bit positions, reset values and timing counts of the PHY LED and control registers
`ifndef PHY_CTL_CFG_SVH
`define PHY_CTL_CFG_SVH

// ****************************************
// Register offsets (management register index)
// ****************************************
`define ADDR_LED_OVERRIDE 5'h18
`define ADDR_PHY_CONTROL 5'h19

// ****************************************
// LED override register fields
// ****************************************
`define LED_FIELD_MSB 5
`define LED_SPEED_EN_BIT 5
`define LED_LINK_EN_BIT 4
`define LED_ACT_EN_BIT 3
`define LED_SPEED_VAL_BIT 2
`define LED_LINK_VAL_BIT 1
`define LED_ACT_VAL_BIT 0
`define LED_OVERRIDE_RESET 6'h00

// ****************************************
// PHY control register fields
// ****************************************
`define PHY_AUTO_X_BIT 15
`define PHY_FORCED_X_BIT 14
`define PHY_PAUSE_RX_BIT 13
`define PHY_PAUSE_TX_BIT 12
`define PHY_INJECT_BIT 11
`define PHY_SEQ_SEL_BIT 10
`define PHY_PASS_BIT 9
`define PHY_RUN_BIT 8
`define PHY_BYPASS_BIT 7

// ****************************************
// Pause advertisement bits (within the 2-bit field)
// ****************************************
`define ADV_PAUSE_BIT 0
`define ADV_ASYM_BIT 1

// ****************************************
// Self-test sequence constants
// ****************************************
`define PRBS_SEED 15'h7fff
`define PRBS_WARMUP 4'hf

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 50
`define LED_STRETCH_TIME_MS 100
`define LED_STRETCH_CYCLES (`LED_STRETCH_TIME_MS * 1000000 / `CLOCK_PERIOD_NS)

`endif

// [hw/phy_ctl_pkg.sv]
// Types shared by the PHY LED and control register block
package phy_ctl_pkg;

    // ****************************************
    // Carriers
    // ****************************************
    // Raw LED status from the PHY core
    typedef struct packed {
        logic speed;
        logic link;
        logic activity;
    } led_status_t;

    // Pause advertisement pair: [1] asymmetric, [0] symmetric
    typedef struct packed {
        logic [1:0] local_adv;
        logic [1:0] partner_adv;
    } pause_adv_t;

    // ****************************************
    // State of the LED stretcher
    // ****************************************
    typedef struct packed {
        logic [23:0] count;
        logic out;
    } stretch_state_t;

    // ****************************************
    // State of the register block
    // ****************************************
    typedef struct packed {
        logic [5:0] led_override;
        logic auto_crossover_en;
        logic forced_crossover;
        logic pause_rx;
        logic pause_tx;
        logic selftest_error_inject;
        logic selftest_sequence_select;
        logic selftest_run;
        logic led_stretch_bypass;
        logic selftest_fail;
        logic [14:0] prbs_gen;
        logic [14:0] prbs_chk;
        logic [3:0] warmup;
        logic tx_bit;
        led_status_t led_out;
        logic [15:0] rd_data;
    } ctl_state_t;

endpackage

// [hw/led_stretch.sv]
// LED pulse stretcher with a bypass
`timescale 1ns/1ps
`include "phy_ctl_cfg.svh"

module led_stretch
    import phy_ctl_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = `LED_STRETCH_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic raw,
    input wire logic bypass,
    output logic stretched
);

    localparam logic [23:0] LOAD = 24'(STRETCH_CYCLES - 1);

    stretch_state_t s_reg; // Registered state
    stretch_state_t s_next; // Next state

    // Reload on every active sample, count down otherwise
    always_comb begin
        s_next = s_reg;
        if (raw) begin
            s_next.count = LOAD;
        end else if (s_reg.count != 24'h0) begin
            s_next.count = s_reg.count - 24'h1;
        end
        // Bypass shows the raw status directly
        s_next.out = bypass ? raw : (raw | (s_reg.count != 24'h0));
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign stretched = s_reg.out;

endmodule

// [hw/phy_led_bist_mdix_control.sv]
// LED override, crossover, pause resolution and packet self-test control registers
//
// Functional notes
// - LED register bits 15:6 ignore writes, read zero
// - Speed override enable drives stored speed value
// - Link override enable drives stored link value
// - Activity override enable drives stored activity value
// - LED register reads return stored bits only
// - Auto crossover enable resets from strap pin
// - Forced crossover swaps transmit and receive pairs
// - Pause receive flag resolved from advertisements
// - Pause transmit flag resolved from advertisements
// - Pause flags only for full duplex result
// - Error inject inserts one error, self clears
// - Pass flag; failure latched until test stops
// - Stretch bypass drives LEDs from raw status
`timescale 1ns/1ps
`include "phy_ctl_cfg.svh"

module phy_led_bist_mdix_control
    import phy_ctl_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = `LED_STRETCH_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rd_data,
    input wire logic strap_auto_crossover,
    input wire logic autoneg_complete,
    input wire logic hcd_full_duplex,
    input wire pause_adv_t pause_adv,
    input wire led_status_t led_status,
    input wire logic selftest_rx_bit,
    output logic selftest_tx_bit,
    output logic selftest_active,
    output logic auto_crossover_en,
    output logic forced_crossover,
    output logic pause_rx_en,
    output logic pause_tx_en,
    output logic speed_led_out,
    output logic link_led_out,
    output logic activity_collision_led_out
);

    // ****************************************
    // Declarations
    // ****************************************
    ctl_state_t s_reg; // Registered state
    ctl_state_t s_next; // Next state
    led_status_t stretched; // Stretched LED status
    logic wr_led; // Write to the LED override register
    logic wr_phy; // Write to the PHY control register
    logic prbs_fb; // Generator feedback bit
    logic prbs_expect; // Checker prediction
    logic pause_ok; // Resolution ended in full duplex
    logic inject_fire; // Pending error goes out now, checker locked
    logic [15:0] phy_view; // Read view of the PHY control register

    assign wr_led = reg_wr && (reg_addr == `ADDR_LED_OVERRIDE);
    assign wr_phy = reg_wr && (reg_addr == `ADDR_PHY_CONTROL);

    // ****************************************
    // LED stretchers
    // ****************************************
    // One stretcher per LED; bypass comes from the control register
    led_stretch #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_stretch_speed (
        .clock(clock),
        .srst(srst),
        .raw(led_status.speed),
        .bypass(s_reg.led_stretch_bypass),
        .stretched(stretched.speed)
    );
    led_stretch #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_stretch_link (
        .clock(clock),
        .srst(srst),
        .raw(led_status.link),
        .bypass(s_reg.led_stretch_bypass),
        .stretched(stretched.link)
    );
    led_stretch #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_stretch_act (
        .clock(clock),
        .srst(srst),
        .raw(led_status.activity),
        .bypass(s_reg.led_stretch_bypass),
        .stretched(stretched.activity)
    );

    // ****************************************
    // Combinational helpers
    // ****************************************
    // Sequence feedback taps for the long and short sequence
    always_comb begin
        if (s_reg.selftest_sequence_select) begin
            prbs_fb = s_reg.prbs_gen[14] ^ s_reg.prbs_gen[13];
            prbs_expect = s_reg.prbs_chk[14] ^ s_reg.prbs_chk[13];
        end else begin
            prbs_fb = s_reg.prbs_gen[8] ^ s_reg.prbs_gen[4];
            prbs_expect = s_reg.prbs_chk[8] ^ s_reg.prbs_chk[4];
        end
    end

    // Pause flags qualified by a full duplex outcome
    assign pause_ok = autoneg_complete && hcd_full_duplex;

    // Inject waits until the checker has locked; an error in its warm-up would go unseen
    assign inject_fire = s_reg.selftest_error_inject && s_reg.selftest_run
        && (s_reg.warmup == `PRBS_WARMUP);

    // Read view of the PHY control register, lower bits zero
    always_comb begin
        phy_view = 16'h0000;
        phy_view[`PHY_AUTO_X_BIT] = s_reg.auto_crossover_en;
        phy_view[`PHY_FORCED_X_BIT] = s_reg.forced_crossover;
        phy_view[`PHY_PAUSE_RX_BIT] = s_reg.pause_rx;
        phy_view[`PHY_PAUSE_TX_BIT] = s_reg.pause_tx;
        phy_view[`PHY_INJECT_BIT] = s_reg.selftest_error_inject;
        phy_view[`PHY_SEQ_SEL_BIT] = s_reg.selftest_sequence_select;
        phy_view[`PHY_PASS_BIT] = s_reg.selftest_run && !s_reg.selftest_fail;
        phy_view[`PHY_RUN_BIT] = s_reg.selftest_run;
        phy_view[`PHY_BYPASS_BIT] = s_reg.led_stretch_bypass;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.rd_data = 16'h0000;

        // LED override register; only bits 5:0 are stored
        if (wr_led) begin
            s_next.led_override = reg_wr_data[`LED_FIELD_MSB:0];
        end

        // Hardware clear of the inject bit once the error went out
        if (inject_fire) begin
            s_next.selftest_error_inject = 1'b0;
        end

        // PHY control writable bits; a new inject write wins over the clear
        if (wr_phy) begin
            s_next.auto_crossover_en = reg_wr_data[`PHY_AUTO_X_BIT];
            s_next.forced_crossover = reg_wr_data[`PHY_FORCED_X_BIT];
            s_next.selftest_sequence_select = reg_wr_data[`PHY_SEQ_SEL_BIT];
            s_next.selftest_run = reg_wr_data[`PHY_RUN_BIT];
            s_next.led_stretch_bypass = reg_wr_data[`PHY_BYPASS_BIT];
            if (reg_wr_data[`PHY_INJECT_BIT]) begin
                s_next.selftest_error_inject = 1'b1;
            end
        end

        // Pause resolution: both symmetric, or asymmetric one way
        s_next.pause_rx = 1'b0;
        s_next.pause_tx = 1'b0;
        if (pause_ok) begin
            if (pause_adv.local_adv[`ADV_PAUSE_BIT] && pause_adv.partner_adv[`ADV_PAUSE_BIT]) begin
                s_next.pause_rx = 1'b1;
                s_next.pause_tx = 1'b1;
            end else if (pause_adv.local_adv == 2'b10 && pause_adv.partner_adv == 2'b11) begin
                s_next.pause_tx = 1'b1;
            end else if (pause_adv.local_adv == 2'b11 && pause_adv.partner_adv == 2'b10) begin
                s_next.pause_rx = 1'b1;
            end
        end

        // Packet self-test generator and self-synchronising checker
        // Idle line and checker history hold the seed level, so stale bits ahead of the
        // stream look like the seed and cannot trip the checker once warm-up is over
        if (!s_reg.selftest_run) begin
            s_next.prbs_gen = `PRBS_SEED;
            s_next.prbs_chk = `PRBS_SEED;
            s_next.warmup = 4'h0;
            s_next.selftest_fail = 1'b0;
            s_next.tx_bit = 1'b1;
        end else begin
            s_next.prbs_gen = {s_reg.prbs_gen[13:0], prbs_fb};
            s_next.tx_bit = prbs_fb ^ inject_fire;
            s_next.prbs_chk = {s_reg.prbs_chk[13:0], selftest_rx_bit};
            if (s_reg.warmup != `PRBS_WARMUP) begin
                s_next.warmup = s_reg.warmup + 4'h1;
            end else if (selftest_rx_bit != prbs_expect) begin
                s_next.selftest_fail = 1'b1;
            end
        end

        // LED outputs: override first, else stretched or raw status
        s_next.led_out.speed = s_reg.led_override[`LED_SPEED_EN_BIT] ?
            s_reg.led_override[`LED_SPEED_VAL_BIT] : stretched.speed;
        s_next.led_out.link = s_reg.led_override[`LED_LINK_EN_BIT] ?
            s_reg.led_override[`LED_LINK_VAL_BIT] : stretched.link;
        s_next.led_out.activity = s_reg.led_override[`LED_ACT_EN_BIT] ?
            s_reg.led_override[`LED_ACT_VAL_BIT] : stretched.activity;

        // Read data, valid in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_LED_OVERRIDE: begin
                    s_next.rd_data = {10'h000, s_reg.led_override};
                end
                `ADDR_PHY_CONTROL: begin
                    s_next.rd_data = phy_view;
                end
                default: begin
                    s_next.rd_data = 16'h0000;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Strap level is caught while reset is held
    always_ff @(posedge clock) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.led_override <= `LED_OVERRIDE_RESET;
            s_reg.auto_crossover_en <= strap_auto_crossover;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rd_data = s_reg.rd_data;
    assign selftest_tx_bit = s_reg.tx_bit;
    assign selftest_active = s_reg.selftest_run;
    assign auto_crossover_en = s_reg.auto_crossover_en;
    assign forced_crossover = s_reg.forced_crossover;
    assign pause_rx_en = s_reg.pause_rx;
    assign pause_tx_en = s_reg.pause_tx;
    assign speed_led_out = s_reg.led_out.speed;
    assign link_led_out = s_reg.led_out.link;
    assign activity_collision_led_out = s_reg.led_out.activity;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Write of 1 to the inject bit
    sequence seq_inject_write;
        wr_phy && reg_wr_data[`PHY_INJECT_BIT];
    endsequence

    // Inject going out with the checker locked, with no fresh write
    sequence seq_inject_consumed;
        inject_fire && !(wr_phy && reg_wr_data[`PHY_INJECT_BIT]);
    endsequence

    // Read strobe to the LED override register
    sequence seq_led_read;
        reg_rd && reg_addr == `ADDR_LED_OVERRIDE;
    endsequence

    a_reserved_read_zero: assert property (seq_led_read |=> reg_rd_data[15:6] == 10'h000)
        else $error("LED register reserved bits read non-zero");
    a_led_readback: assert property (seq_led_read |=> reg_rd_data[5:0] == $past(s_reg.led_override))
        else $error("LED register read does not match stored bits");
    a_speed_led_force: assert property (
        s_reg.led_override[`LED_SPEED_EN_BIT] |=> speed_led_out == $past(s_reg.led_override[`LED_SPEED_VAL_BIT]))
        else $error("Speed LED not driven by override value");
    a_link_led_force: assert property (
        s_reg.led_override[`LED_LINK_EN_BIT] |=> link_led_out == $past(s_reg.led_override[`LED_LINK_VAL_BIT]))
        else $error("Link LED not driven by override value");
    a_act_led_force: assert property (
        s_reg.led_override[`LED_ACT_EN_BIT] |=> activity_collision_led_out == $past(s_reg.led_override[`LED_ACT_VAL_BIT]))
        else $error("Activity LED not driven by override value");
    a_inject_single_error: assert property (seq_inject_consumed |=> !s_reg.selftest_error_inject ##0 selftest_tx_bit != $past(prbs_fb))
        else $error("Error inject did not flip one bit and clear");
    a_inject_sets: assert property (seq_inject_write |=> s_reg.selftest_error_inject)
        else $error("Error inject write lost");
    a_pause_half_duplex: assert property (!pause_ok |=> !pause_rx_en && !pause_tx_en)
        else $error("Pause flag set without full duplex resolution");
    a_pause_symmetric: assert property (pause_ok && pause_adv.local_adv[0] && pause_adv.partner_adv[0]
        |=> pause_rx_en && pause_tx_en)
        else $error("Symmetric pause not resolved");
    a_fail_cleared_on_stop: assert property (!s_reg.selftest_run |=> !s_reg.selftest_fail [*2])
        else $error("Self-test failure not cleared when stopped");
    a_fail_latched: assert property (s_reg.selftest_fail && s_reg.selftest_run && !wr_phy |=> s_reg.selftest_fail)
        else $error("Self-test failure not latched");
    a_stretch_bypass: assert property (s_reg.led_stretch_bypass && !s_reg.led_override[`LED_LINK_EN_BIT]
        && $stable(s_reg.led_stretch_bypass) |=> link_led_out == $past(stretched.link))
        else $error("Link LED not following status path");
    a_strap_capture: assert property (disable iff (1'b0) srst |=> auto_crossover_en == $past(strap_auto_crossover))
        else $error("Crossover enable not taken from strap");

endmodule

// [tb/tb.sv]
// Self-checking testbench of the PHY LED and control register block
`timescale 1ns/1ps
`include "phy_ctl_cfg.svh"

module tb
    import phy_ctl_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    // Expected read word and expected output pins
    typedef struct packed {
        logic [15:0] rd;
        logic [7:0] pins;
    } note_t;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wr_data = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rd_data;
    logic strap_auto_crossover = 1'b1;
    logic autoneg_complete = 1'b0;
    logic hcd_full_duplex = 1'b0;
    pause_adv_t pause_adv = 4'h0;
    led_status_t led_status = 3'h0;
    logic selftest_rx_bit = 1'b0;
    logic selftest_tx_bit, selftest_active, auto_crossover_en, forced_crossover;
    logic pause_rx_en, pause_tx_en, speed_led_out, link_led_out, activity_collision_led_out;
    note_t notes[$]; // Pending read expectations
    logic rd_seen_reg = 1'b0; // A read was taken at the last edge
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] rng_state = 32'hc6a2_78d8;
    // Expected outputs, kept by the driver
    logic ax, fx, prx, ptx, run_exp;
    logic [2:0] led_exp;
    logic [59:0] bits;

    // ****************************************
    // Clock, device and loopback
    // ****************************************
    // 20 MHz clock
    always #25 clock = ~clock;

    phy_led_bist_mdix_control #(.STRETCH_CYCLES(8)) uut (
        .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
        .strap_auto_crossover(strap_auto_crossover), .autoneg_complete(autoneg_complete),
        .hcd_full_duplex(hcd_full_duplex), .pause_adv(pause_adv), .led_status(led_status),
        .selftest_rx_bit(selftest_rx_bit), .selftest_tx_bit(selftest_tx_bit),
        .selftest_active(selftest_active), .auto_crossover_en(auto_crossover_en),
        .forced_crossover(forced_crossover), .pause_rx_en(pause_rx_en), .pause_tx_en(pause_tx_en),
        .speed_led_out(speed_led_out), .link_led_out(link_led_out),
        .activity_collision_led_out(activity_collision_led_out)
    );

    // Test stream looped back with one cycle of line delay
    always @(posedge clock) begin
        selftest_rx_bit <= selftest_tx_bit;
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Xorshift random source
    function automatic logic [31:0] next_rand();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction

    // Expected pin vector from the driver's model
    function automatic logic [7:0] pins_now();
        return {ax, fx, prx, ptx, run_exp, led_exp};
    endfunction

    // Pause resolution: returns {rx, tx}
    function automatic logic [1:0] pause_of(input logic [1:0] l, input logic [1:0] p, input logic ok);
        if (!ok) begin
            return 2'b00;
        end else if (l[0] && p[0]) begin
            return 2'b11;
        end else if (l == 2'b10 && p == 2'b11) begin
            return 2'b01;
        end else if (l == 2'b11 && p == 2'b10) begin
            return 2'b10;
        end
        return 2'b00;
    endfunction

    // Compares one value and counts
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // One-cycle write; strobe left for the next operation to drop
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clock);
    endtask

    // One-cycle read; the expectation goes to the monitor's queue
    task automatic rd(input logic [4:0] a, input logic [15:0] d, input logic [7:0] p);
        notes.push_back('{rd: d, pins: p});
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
    endtask

    // Bus idle for n cycles
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // Verdict and end of run
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // Monitor: read data and pins in the cycle after each read
    // ****************************************
    always @(posedge clock) begin
        if (rd_seen_reg) begin
            check(reg_rd_data, notes[0].rd);
            check({8'h00, auto_crossover_en, forced_crossover, pause_rx_en, pause_tx_en, selftest_active,
                   speed_led_out, link_led_out, activity_collision_led_out}, notes[0].pins);
            void'(notes.pop_front());
        end
        rd_seen_reg <= reg_rd;
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [15:0] d;
        logic [1:0] pr;
        logic ok_a, ok_b;
        int len, tap;
        {fx, prx, ptx, run_exp, led_exp} = 7'h00;
        ax = 1'b1;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        // Reset values, unmapped place, back-to-back reads
        rd(`ADDR_LED_OVERRIDE, 16'h0000, pins_now());
        rd(`ADDR_PHY_CONTROL, 16'h8000, pins_now());
        wr(5'h1a, 16'hffff);
        rd(5'h00, 16'h0000, pins_now());
        rd(`ADDR_LED_OVERRIDE, 16'h0000, pins_now());
        // Overrides against random raw status, stretching bypassed
        wr(`ADDR_PHY_CONTROL, 16'h8080);
        for (int i = 0; i < 12; i++) begin
            v = next_rand();
            led_status <= v[18:16];
            wr(`ADDR_LED_OVERRIDE, v[15:0]);
            idle(4);
            led_exp = {v[5] ? v[2] : v[18], v[4] ? v[1] : v[17], v[3] ? v[0] : v[16]};
            rd(`ADDR_LED_OVERRIDE, {10'h000, v[5:0]}, pins_now());
        end
        // Stretching on, then bypassed
        wr(`ADDR_LED_OVERRIDE, 16'h0000);
        for (int b = 0; b < 2; b++) begin
            wr(`ADDR_PHY_CONTROL, b ? 16'h8080 : 16'h8000);
            led_status <= 3'h7;
            idle(6);
            led_exp = 3'h7;
            rd(`ADDR_LED_OVERRIDE, 16'h0000, pins_now());
            led_status <= 3'h0;
            idle(3);
            led_exp = b ? 3'h0 : 3'h7;
            rd(`ADDR_LED_OVERRIDE, 16'h0000, pins_now());
            idle(20);
            led_exp = 3'h0;
        end
        // Random control words; read-only and unused bits must not stick
        for (int i = 0; i < 8; i++) begin
            v = next_rand();
            d = v[15:0] & 16'hf6ff;
            wr(`ADDR_PHY_CONTROL, d);
            idle(3);
            ax = d[15];
            fx = d[14];
            rd(`ADDR_PHY_CONTROL, d & 16'hc480, pins_now());
        end
        // Pause resolution over every advertisement and qualifier
        wr(`ADDR_PHY_CONTROL, 16'h0000);
        {ax, fx} = 2'b00;
        for (int i = 0; i < 64; i++) begin
            pause_adv <= i[3:0];
            autoneg_complete <= i[4];
            hcd_full_duplex <= i[5];
            idle(3);
            pr = pause_of(i[3:2], i[1:0], i[4] && i[5]);
            {prx, ptx} = pr;
            rd(`ADDR_PHY_CONTROL, {2'b00, pr, 12'h000}, pins_now());
        end
        autoneg_complete <= 1'b0;
        idle(3);
        {prx, ptx} = 2'b00;
        // Self-test with each sequence: pass, and the stream obeys its recurrence
        for (int s = 0; s < 2; s++) begin
            wr(`ADDR_PHY_CONTROL, s ? 16'h0500 : 16'h0100);
            run_exp = 1'b1;
            idle(30);
            for (int n = 0; n < 60; n++) begin
                @(posedge clock);
                bits[n] = selftest_tx_bit;
            end
            len = s ? 15 : 9;
            tap = s ? 14 : 5;
            ok_a = 1'b1;
            ok_b = 1'b1;
            for (int n = 15; n < 60; n++) begin
                ok_a &= (bits[n] === (bits[n - len] ^ bits[n - tap]));
                ok_b &= (bits[n] === (bits[n - len] ^ bits[n - len + tap]));
            end
            check({15'h0000, ok_a | ok_b}, 16'h0001);
            rd(`ADDR_PHY_CONTROL, s ? 16'h0700 : 16'h0300, pins_now());
            wr(`ADDR_PHY_CONTROL, 16'h0000);
            run_exp = 1'b0;
            idle(3);
        end
        // Injection waits for a run, fires once, clears itself; failure latches until stop
        wr(`ADDR_PHY_CONTROL, 16'h0800);
        idle(3);
        rd(`ADDR_PHY_CONTROL, 16'h0800, pins_now());
        wr(`ADDR_PHY_CONTROL, 16'h0900);
        run_exp = 1'b1;
        idle(40);
        rd(`ADDR_PHY_CONTROL, 16'h0100, pins_now());
        idle(40);
        rd(`ADDR_PHY_CONTROL, 16'h0100, pins_now());
        wr(`ADDR_PHY_CONTROL, 16'h0000);
        run_exp = 1'b0;
        idle(3);
        rd(`ADDR_PHY_CONTROL, 16'h0000, pins_now());
        wr(`ADDR_PHY_CONTROL, 16'h0100);
        run_exp = 1'b1;
        idle(40);
        rd(`ADDR_PHY_CONTROL, 16'h0300, pins_now());
        // Second reset with the strap low
        strap_auto_crossover <= 1'b0;
        srst <= 1'b1;
        idle(20);
        srst <= 1'b0;
        @(posedge clock);
        {ax, run_exp} = 2'b00;
        rd(`ADDR_PHY_CONTROL, 16'h0000, pins_now());
        idle(3);
        results();
    end
endmodule
